// >>> eag_map.vh
`ifndef EAG_MAP_VH
`define EAG_MAP_VH
// Register word indices on the Avalon-MM slave (byte address = 4 * index)
`define EAG_IDX_CTRL      3'h0
`define EAG_IDX_XSTART    3'h1
`define EAG_IDX_XEND      3'h2
`define EAG_IDX_YSTART    3'h3
`define EAG_IDX_YEND      3'h4
`define EAG_IDX_STATUS    3'h5
// Circular buffer control fields
`define EAG_CTRL_XSEL_LO  0
`define EAG_CTRL_YSEL_LO  4
`define EAG_CTRL_YEN_BIT  14
`define EAG_CTRL_XEN_BIT  15
`define EAG_CTRL_RESET    16'h00FF
`define EAG_SEL_OFF       4'hF
`define EAG_PTR_RESET     16'h0000
// Field widths and limits
`define EAG_NEAR_W        13
`define EAG_NEAR_BYTES    8192
`define EAG_LIT5_W        5
`define EAG_LIT10_W       10
`define EAG_LIT14_W       14
`define EAG_LIT16_W       16
`define EAG_MAX_WORDS     32768
`define EAG_DEFAULT_REG   4'h0
// Addressing modes
`define EAG_M_DIRECT      3'h0
`define EAG_M_IND         3'h1
`define EAG_M_POST        3'h2
`define EAG_M_PRE         3'h3
`define EAG_M_INDEX       3'h4
`define EAG_M_LITOFF      3'h5
`define EAG_M_FILE        3'h6
`define EAG_M_LIT         3'h7
// Instruction classes
`define EAG_C_MCU         2'h0
`define EAG_C_MOVE        2'h1
`define EAG_C_MAC         2'h2
`define EAG_C_OTHER       2'h3
`endif

// >>> eag_regfile.v
`timescale 1ns/1ps
// Sixteen working registers, two read ports with registered data
module eag_regfile (
   clk,
   nrst,
   ra_a,
   ra_b,
   we,
   wa,
   wd,
   rd_a,
   rd_b
);
   input  wire        clk;
   input  wire        nrst;
   input  wire [3:0]  ra_a;
   input  wire [3:0]  ra_b;
   input  wire        we;
   input  wire [3:0]  wa;
   input  wire [15:0] wd;
   output reg  [15:0] rd_a;
   output reg  [15:0] rd_b;

   reg [15:0] mem [0:15];
   integer    i;

   // Write-first so a pointer update is seen by the next read
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (i = 0; i < 16; i = i + 1) begin
            mem[i] <= 16'h0000;
         end
         rd_a <= 16'h0000;
         rd_b <= 16'h0000;
      end else begin
         if (we) begin
            mem[wa] <= wd;
         end
         rd_a <= (we && wa == ra_a) ? wd : mem[ra_a];
         rd_b <= (we && wa == ra_b) ? wd : mem[ra_b];
      end
   end
endmodule

// >>> eag_core.v
`timescale 1ns/1ps
`include "eag_map.vh"
//Contract
// - File direct uses 13 bits, near 8192 bytes
// - W0 default register; result to file or W0
// - Move forms full 16-bit addresses
// - MCU operand 1 register direct; operand 2 flexible
// - Indirect: address is pointer, pointer unchanged
// - Post-modify: issue pointer, then adjust
// - Pre-modify: adjust by signed constant, then issue
// - Indexed: pointer plus offset register
// - Literal offset: pointer plus instruction literal
// - Move modes differ; one shared offset field
// - MCU takes 5-bit or 10-bit literals
// - MAC pointers W8-W11; W8/9 X, W10/11 Y
// - MAC indexed only W9 in X, W11 Y
// - MAC post-modify only by 2, 4, 6 (code also accepts a step of 0)
// - Branch 16-bit signed, disable 14-bit literal
// - One circular buffer each in X and Y
// - Power-of-two buffers check both bounds
// - 16-bit start/end; length at most 32K words
// - Y circular addresses force bit 0 clear
// - Select field 15 disables that space's wrapping
// - X wraps when select not 15 and bit 15
// - Y wraps when select not 15 and bit 14
// - Write wrapped value back only for pre/post
module eag_core (
   clk,
   nrst,
   avs_address,
   avs_read,
   avs_write,
   avs_writedata,
   avs_readdata,
   avs_waitrequest,
   avs_response,
   op_valid,
   op_class,
   op_mode,
   op_ptr,
   op_off,
   op_mod,
   op_lit,
   op_dest_file,
   op_is_write,
   op_ready,
   ea_valid,
   ea_addr,
   ea_space_y,
   ea_write,
   ea_literal,
   ea_illegal,
   dest_reg
);
   input  wire        clk;
   input  wire        nrst;
   input  wire [2:0]  avs_address;
   input  wire        avs_read;
   input  wire        avs_write;
   input  wire [31:0] avs_writedata;
   output reg  [31:0] avs_readdata;
   output wire        avs_waitrequest;
   output reg  [1:0]  avs_response;
   input  wire        op_valid;
   input  wire [1:0]  op_class;
   input  wire [2:0]  op_mode;
   input  wire [3:0]  op_ptr;
   input  wire [3:0]  op_off;
   input  wire [3:0]  op_mod;
   input  wire [15:0] op_lit;
   input  wire        op_dest_file;
   input  wire        op_is_write;
   output wire        op_ready;
   output reg         ea_valid;
   output reg  [15:0] ea_addr;
   output reg         ea_space_y;
   output reg         ea_write;
   output reg  [15:0] ea_literal;
   output reg         ea_illegal;
   output reg  [3:0]  dest_reg;

   // One-hot operation sequencer
   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_FETCH = 3'b010;
   localparam [2:0] ST_ISSUE = 3'b100;

   reg [2:0]  state_q;
   reg [15:0] ctrl_q;
   reg [15:0] xs_q;
   reg [15:0] xe_q;
   reg [15:0] ys_q;
   reg [15:0] ye_q;
   reg [15:0] wraps_q;
   reg        bus_ack_q;
   reg [1:0]  cls_q;
   reg [2:0]  mode_q;
   reg [3:0]  ptr_q;
   reg [3:0]  off_q;
   reg [3:0]  mod_q;
   reg [15:0] lit_q;
   reg        dfile_q;
   reg        wr_q;
   wire [15:0] pv;
   wire [15:0] ov;
   wire [15:0] wb_val;
   wire        wb_en;

   // Sign-extended 4-bit modifier, used by pre/post modes
   function [15:0] sext4;
      input [3:0] v;
      begin
         sext4 = {{12{v[3]}}, v};
      end
   endfunction

   // Wrap an address into [s, e]; count as wrapped if corrected
   function [16:0] wrap;
      input [15:0] a;
      input [15:0] s;
      input [15:0] e;
      input        en;
      reg   [15:0] span;
      begin
         span = e - s + 16'h0001;
         wrap = {1'b0, a};
         if (en && a > e) begin
            wrap = {1'b1, a - span};
         end else if (en && a < s) begin
            wrap = {1'b1, a + span};
         end
      end
   endfunction

   // Read ports follow the request while idle, then the held operation;
   // the offset is held too, as the decoder drops it after the take
   wire [3:0] rf_ra_a = (state_q == ST_IDLE) ? op_ptr : ptr_q;
   wire [3:0] rf_ra_b = (state_q == ST_IDLE) ? op_off : off_q;

   // Register file; port A pointer, port B offset
   eag_regfile u_rf (
      .clk  (clk),
      .nrst (nrst),
      .ra_a (rf_ra_a),
      .ra_b (rf_ra_b),
      .we   (wb_en),
      .wa   (ptr_q),
      .wd   (wb_val),
      .rd_a (pv),
      .rd_b (ov)
   );

   // Register bus: one wait cycle, then acknowledge
   assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack_q;

   // Bus registers; read data is captured in the wait cycle
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus_ack_q    <= 1'b0;
         avs_readdata <= 32'h00000000;
         avs_response <= 2'h0;
         ctrl_q       <= `EAG_CTRL_RESET;
         xs_q         <= `EAG_PTR_RESET;
         xe_q         <= `EAG_PTR_RESET;
         ys_q         <= `EAG_PTR_RESET;
         ye_q         <= `EAG_PTR_RESET;
      end else begin
         bus_ack_q <= (avs_read | avs_write) & ~bus_ack_q;
         if ((avs_read | avs_write) & ~bus_ack_q) begin
            avs_response <= (avs_address > `EAG_IDX_STATUS) ? 2'h2 : 2'h0;
            case (avs_address)
               `EAG_IDX_CTRL:   avs_readdata <= {16'h0000, ctrl_q};
               `EAG_IDX_XSTART: avs_readdata <= {16'h0000, xs_q};
               `EAG_IDX_XEND:   avs_readdata <= {16'h0000, xe_q};
               `EAG_IDX_YSTART: avs_readdata <= {16'h0000, ys_q};
               `EAG_IDX_YEND:   avs_readdata <= {16'h0000, ye_q};
               `EAG_IDX_STATUS: avs_readdata <= {16'h0000, wraps_q};
               default:         avs_readdata <= 32'h00000000;
            endcase
         end
         // Write lands on the acknowledge edge only
         if (avs_write & bus_ack_q) begin
            case (avs_address)
               `EAG_IDX_CTRL:   ctrl_q <= avs_writedata[15:0];
               `EAG_IDX_XSTART: xs_q   <= avs_writedata[15:0];
               `EAG_IDX_XEND:   xe_q   <= avs_writedata[15:0];
               `EAG_IDX_YSTART: ys_q   <= avs_writedata[15:0];
               `EAG_IDX_YEND:   ye_q   <= avs_writedata[15:0];
               default:         ;
            endcase
         end
      end
   end

   // Circular enables, one buffer per space
   wire [3:0] xsel = ctrl_q[`EAG_CTRL_XSEL_LO+3:`EAG_CTRL_XSEL_LO];
   wire [3:0] ysel = ctrl_q[`EAG_CTRL_YSEL_LO+3:`EAG_CTRL_YSEL_LO];
   wire x_on = (xsel != `EAG_SEL_OFF) && ctrl_q[`EAG_CTRL_XEN_BIT];
   wire y_on = (ysel != `EAG_SEL_OFF) && ctrl_q[`EAG_CTRL_YEN_BIT];

   // MAC: W8..W11 only, W10/11 go to Y space
   wire mac = (cls_q == `EAG_C_MAC);
   wire mac_y = mac && ptr_q[1];
   wire mac_ptr_ok = (ptr_q[3:2] == 2'b10);
   wire mac_idx_ok = (ptr_q == 4'h9) || (ptr_q == 4'hB);
   wire mac_mod_ok = (mod_q == 4'h0) || (mod_q == 4'h2) ||
                     (mod_q == 4'h4) || (mod_q == 4'h6);
   reg  mac_bad;

   // Illegal MAC operands are flagged and never write back
   always @* begin
      mac_bad = 1'b0;
      if (mac) begin
         case (mode_q)
            `EAG_M_IND:   mac_bad = ~mac_ptr_ok;
            `EAG_M_POST:  mac_bad = ~mac_ptr_ok | ~mac_mod_ok;
            `EAG_M_INDEX: mac_bad = ~mac_idx_ok;
            default:      mac_bad = 1'b1;
         endcase
      end
   end

   // Raw address and pointer update per mode
   reg [15:0] raw;
   reg [15:0] upd;
   reg        is_mem;
   reg        do_wb;
   wire [15:0] stepped = pv + sext4(mod_q);

   always @* begin
      raw    = pv;
      upd    = pv;
      is_mem = 1'b1;
      do_wb  = 1'b0;
      case (mode_q)
         `EAG_M_IND: raw = pv;
         `EAG_M_POST: begin
            raw   = pv;
            upd   = stepped;
            do_wb = 1'b1;
         end
         `EAG_M_PRE: begin
            raw   = stepped;
            upd   = stepped;
            do_wb = 1'b1;
         end
         `EAG_M_INDEX: raw = pv + ov;
         `EAG_M_LITOFF: raw = pv + lit_q;
         `EAG_M_FILE: begin
            // Move reaches all of data space, others near only
            if (cls_q == `EAG_C_MOVE) begin
               raw = lit_q;
            end else begin
               raw = {3'b000, lit_q[`EAG_NEAR_W-1:0]};
            end
         end
         default: is_mem = 1'b0;
      endcase
   end

   // Space and wrapping; X wrap covers reads and writes alike
   wire in_y = mac_y;
   wire sel_hit = in_y ? (ptr_q == ysel && y_on) : (ptr_q == xsel && x_on);
   wire mod_ok = sel_hit && (mode_q != `EAG_M_FILE) &&
                 is_mem;
   wire [15:0] bs = in_y ? ys_q : xs_q;
   wire [15:0] be = in_y ? ye_q : xe_q;
   // Both bounds checked; one-way buffers simply never cross the other
   wire [16:0] wa_r = wrap(raw, bs, be, mod_ok);
   wire [16:0] wu_r = wrap(upd, bs, be, mod_ok);
   wire [15:0] ea_n = in_y ? {wa_r[15:1], 1'b0} : wa_r[15:0];
   assign wb_val = in_y && mod_ok ? {wu_r[15:1], 1'b0} : wu_r[15:0];
   assign wb_en  = (state_q == ST_ISSUE) && do_wb && !mac_bad;

   // Literal field widths per class
   reg [15:0] lit_n;
   always @* begin
      case (cls_q)
         `EAG_C_MCU:   lit_n = mod_q[0] ? {6'h00, lit_q[`EAG_LIT10_W-1:0]}
                                        : {11'h000, lit_q[`EAG_LIT5_W-1:0]};
         `EAG_C_OTHER: lit_n = mod_q[0] ? lit_q
                                        : {2'b00, lit_q[`EAG_LIT14_W-1:0]};
         default:      lit_n = lit_q;
      endcase
   end

   // One op in flight; the decoder waits while busy
   assign op_ready = (state_q == ST_IDLE);

   // Capture operation, wait for register read, issue
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q    <= ST_IDLE;
         cls_q      <= 2'h0;
         mode_q     <= 3'h0;
         ptr_q      <= 4'h0;
         off_q      <= 4'h0;
         mod_q      <= 4'h0;
         lit_q      <= 16'h0000;
         dfile_q    <= 1'b0;
         wr_q       <= 1'b0;
         wraps_q    <= 16'h0000;
         ea_valid   <= 1'b0;
         ea_addr    <= 16'h0000;
         ea_space_y <= 1'b0;
         ea_write   <= 1'b0;
         ea_literal <= 16'h0000;
         ea_illegal <= 1'b0;
         dest_reg   <= 4'h0;
      end else begin
         ea_valid <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (op_valid) begin
                  cls_q   <= op_class;
                  mode_q  <= op_mode;
                  ptr_q   <= op_ptr;
                  off_q   <= op_off;
                  mod_q   <= op_mod;
                  lit_q   <= op_lit;
                  dfile_q <= op_dest_file;
                  wr_q    <= op_is_write;
                  state_q <= ST_FETCH;
               end
            end
            ST_FETCH: state_q <= ST_ISSUE;
            ST_ISSUE: begin
               ea_valid   <= 1'b1;
               ea_addr    <= is_mem ? ea_n : 16'h0000;
               ea_space_y <= in_y;
               ea_write   <= wr_q & is_mem;
               ea_literal <= lit_n;
               ea_illegal <= mac_bad;
               // File ops return to the file or the default register
               dest_reg   <= dfile_q ? ptr_q : `EAG_DEFAULT_REG;
               // Status counts corrected addresses, not pointer updates
               if (wa_r[16] && !mac_bad) begin
                  wraps_q <= wraps_q + 16'h0001;
               end
               state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule

// >>> eag_core_chk.sv
`timescale 1ns/1ps
// Timing of operand answers, bus wait state and MAC operand legality
module eag_core_chk (
   input wire        clk,
   input wire        nrst,
   input wire        avs_read,
   input wire        avs_write,
   input wire        avs_waitrequest,
   input wire        op_valid,
   input wire        op_ready,
   input wire [1:0]  op_class,
   input wire [2:0]  op_mode,
   input wire [3:0]  op_ptr,
   input wire [3:0]  op_mod,
   input wire        ea_valid,
   input wire [15:0] ea_addr,
   input wire        ea_space_y,
   input wire        ea_illegal
);
   reg  [1:0] cls_q;
   reg  [2:0] mode_q;
   reg  [3:0] ptr_q;
   reg  [3:0] mod_q;
   wire       mac_hit;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Fields held from take to answer; safe since one op is in flight
   always @(posedge clk or negedge nrst)
      if (!nrst)
         {cls_q, mode_q, ptr_q, mod_q} <= 13'h0000;
      else if (op_valid && op_ready)
         {cls_q, mode_q, ptr_q, mod_q} <= {op_class, op_mode, op_ptr, op_mod};
   assign mac_hit = ea_valid && cls_q == 2'h2;

   property p_answer; op_valid && op_ready |-> ##3 ea_valid; endproperty
   a_answer: assert property (p_answer) else $error("late answer");
   property p_pulse; ea_valid |=> !ea_valid; endproperty
   a_pulse: assert property (p_pulse) else $error("long pulse");
   property p_busy;
      op_valid && op_ready |=> !op_ready [*2] ##1 op_ready;
   endproperty
   a_busy: assert property (p_busy) else $error("ready timing");
   property p_wait;
      $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("wait state");
   property p_near;
      ea_valid && mode_q == 3'h6 && cls_q != 2'h1 |-> ea_addr[15:13] == 3'h0;
   endproperty
   a_near: assert property (p_near) else $error("file addr wide");
   property p_yunit; mac_hit && !ea_illegal |-> ea_space_y == ptr_q[1];
   endproperty
   a_yunit: assert property (p_yunit) else $error("wrong space");
   property p_xonly; ea_valid && cls_q != 2'h2 |-> !ea_space_y; endproperty
   a_xonly: assert property (p_xonly) else $error("y for non mac");
   property p_macptr; mac_hit && ptr_q[3:2] != 2'h2 |-> ea_illegal;
   endproperty
   a_macptr: assert property (p_macptr) else $error("mac ptr");
   property p_macidx;
      mac_hit && mode_q == 3'h4 && !ptr_q[0] |-> ea_illegal;
   endproperty
   a_macidx: assert property (p_macidx) else $error("mac index");
   property p_macmod;
      mac_hit && mode_q == 3'h2 && mod_q[0] |-> ea_illegal;
   endproperty
   a_macmod: assert property (p_macmod) else $error("mac step");
   c_y: cover property (ea_valid && ea_space_y);
   c_bad: cover property (ea_valid && ea_illegal);
   c_wr: cover property ($rose(avs_write));
endmodule
bind eag_core eag_core_chk u_chk (.*);

// >>> eag_dec_model.sv
`timescale 1ns/1ps
// Decoder stand-in: issues one operand request and collects the answer
module eag_dec_model (
   input wire         clk,
   input wire         op_ready,
   input wire         ea_valid,
   input wire  [15:0] ea_addr,
   input wire         ea_space_y,
   input wire         ea_write,
   input wire  [15:0] ea_literal,
   input wire         ea_illegal,
   input wire  [3:0]  dest_reg,
   output logic       op_valid,
   output logic [1:0] op_class,
   output logic [2:0] op_mode,
   output logic [3:0] op_ptr,
   output logic [3:0] op_off,
   output logic [3:0] op_mod,
   output logic [15:0] op_lit,
   output logic       op_dest_file,
   output logic       op_is_write
);
   logic [15:0] addr_r;
   logic [15:0] lit_r;
   logic        y_r;
   logic        ill_r;
   logic [3:0]  dreg_r;
   logic        wr_r;
   int          gap = 0;
   initial {op_valid, op_class, op_mode, op_ptr, op_off, op_mod, op_lit,
            op_dest_file, op_is_write} = 36'h0;
   // Word: write, file flags, class, mode, pointer, offset, step, literal
   task automatic op(input logic [35:0] w);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      op_valid <= 1'b1;
      op_is_write <= w[35];
      op_dest_file <= w[34];
      {op_class, op_mode, op_ptr, op_off, op_mod, op_lit} <= {w[33:32], w[30:0]};
      @(negedge clk);
      while (!op_ready) @(negedge clk);
      @(posedge clk);
      op_valid <= 1'b0;
      // Mode, pointer, offset, step and literal are scrambled so nothing leans on stale values
      {op_mode, op_ptr, op_off, op_mod, op_lit} <= ~w[30:0];
      @(negedge clk);
      while (!ea_valid) @(negedge clk);
      {addr_r, y_r, lit_r, ill_r, dreg_r} =
         {ea_addr, ea_space_y, ea_literal, ea_illegal, dest_reg};
      wr_r = ea_write;
   endtask
endmodule

// >>> eag_core_tb.sv
`timescale 1ns/1ps
// Register bus tasks plus operand requests through the decoder model
module eag_core_tb;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [2:0]  avs_address = 3'h0;
   logic [31:0] avs_writedata = 32'h0;
   wire  [31:0] avs_readdata;
   wire  [1:0]  avs_response, op_class;
   wire         avs_waitrequest, op_valid, op_ready, op_dest_file, op_is_write;
   wire         ea_valid, ea_space_y, ea_write, ea_illegal;
   wire  [2:0]  op_mode;
   wire  [3:0]  op_ptr, op_off, op_mod, dest_reg;
   wire  [15:0] op_lit, ea_addr, ea_literal;
   int          mismatches = 0;
   int          total_checks = 0;
   logic [31:0] q;
   logic [1:0]  resp;

   eag_core dut (.*);
   eag_dec_model dec (.*);
   always #12.5 clk = ~clk;

   task automatic chk(input logic [31:0] seen, exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
         mismatches++;
      end
   endtask
   // Request held until waitrequest is seen low, released after that edge
   task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      @(posedge clk);
      while (avs_waitrequest) @(posedge clk);
      q = avs_readdata;
      resp = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] e);
      bus(1'b0, a, 16'h0000);
      chk(q, {16'h0000, e}, "readdata");
   endtask
   // Expected is illegal flag, Y flag and address (literal for mode 7)
   task automatic ea(input logic [35:0] w, input logic [17:0] e);
      dec.op(w);
      if (e[17])
         chk({31'h0, dec.ill_r}, 32'h1, "ea_illegal");
      else
         chk({14'h0, dec.ill_r, dec.y_r,
              (w[30:28] == 3'h7 ? dec.lit_r : dec.addr_r)}, {14'h0, e}, "ea");
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // The run takes a few hundred cycles; this leaves a wide margin
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      conclude();
   end

   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      rd(3'h0, 16'h00FF);
      bus(1'b0, 3'h6, 16'h0000);
      chk({30'h0, resp}, 32'h2, "response");
      chk(q, 32'h0, "unmapped data");
      bus(1'b1, 3'h1, 16'h0010);
      bus(1'b1, 3'h2, 16'h001F);
      bus(1'b1, 3'h3, 16'h0000);
      bus(1'b1, 3'h4, 16'h0007);
      rd(3'h2, 16'h001F);
      $display("test registers done");
      ea(36'h021020000, 18'h00000);
      ea(36'h011000000, 18'h00002);
      ea(36'h011000000, 18'h00002);
      ea(36'h031040000, 18'h00006);
      ea(36'h022030000, 18'h00000);
      ea(36'h041200000, 18'h00009);
      ea(36'h141200000, 18'h00009);
      ea(36'h151000010, 18'h00016);
      ea(36'h06000FFFF, 18'h01FFF);
      chk({28'h0, dec.dreg_r}, 32'h0, "dest_reg");
      ea(36'hC65000123, 18'h00123);
      chk({28'h0, dec.dreg_r}, 32'h5, "dest_reg");
      chk({31'h0, dec.wr_r}, 32'h1, "ea_write");
      ea(36'h16000FFFF, 18'h0FFFF);
      ea(36'h07000FFFF, 18'h0001F);
      ea(36'h87000FFFF, 18'h0001F);
      chk({31'h0, dec.wr_r}, 32'h0, "ea_write");
      ea(36'h07001FFFF, 18'h003FF);
      ea(36'h37000FFFF, 18'h03FFF);
      ea(36'h37001FFFF, 18'h0FFFF);
      $display("test modes done");
      bus(1'b1, 3'h0, 16'h0004);
      ea(36'h0340F0000, 18'h0FFFF);
      bus(1'b1, 3'h0, 16'h800F);
      ea(36'h0350F0000, 18'h0FFFF);
      bus(1'b1, 3'h0, 16'h8003);
      dec.gap = 3;
      ea(36'h033060000, 18'h00016);
      ea(36'h033060000, 18'h0001C);
      ea(36'h033060000, 18'h00012);
      ea(36'h013000000, 18'h00012);
      ea(36'h0330C0000, 18'h0001E);
      ea(36'h043200000, 18'h00011);
      ea(36'h013000000, 18'h0001E);
      rd(3'h5, 16'h0004);
      dec.gap = 0;
      $display("test x buffer done");
      bus(1'b1, 3'h0, 16'h40AF);
      ea(36'h22A020000, 18'h10000);
      ea(36'h22A060000, 18'h10002);
      ea(36'h02A010000, 18'h00000);
      ea(36'h21A000000, 18'h10000);
      ea(36'h228040000, 18'h00000);
      ea(36'h249200000, 18'h00003);
      ea(36'h248200000, 18'h20000);
      ea(36'h229030000, 18'h20000);
      ea(36'h211000000, 18'h20000);
      $display("test y buffer done");
      conclude();
   end
endmodule
